//--- rtl/fpal_persist.sv
// persistency filter for one fault cause
`timescale 1ns/10ps
`default_nettype none
module fpal_persist import fpal_pkg::*; (
  input  wire logic sys_clk, // system clock
  input  wire logic rst_n,   // async reset, low
  input  wire logic cause,   // gated fault cause
  input  wire logic tick,    // filter tick
  output logic      failed,  // declared failure
  output logic      change   // pulse on declare or clear
);
  logic       causeFf;  // cause last cycle
  logic       failedFf; // declared state
  logic       chgFf;    // change pulse
  logic [6:0] cntFf;    // ticks the cause has held
  logic       nxt_failed;
  logic       nxt_chg;
  logic [6:0] nxt_cnt;
  logic [6:0] limit;
  // timer per cause, restarted on any cause edge
  always_comb begin
    limit      = failedFf ? CLR_TICKS : SET_TICKS;
    nxt_cnt    = cntFf;
    nxt_failed = failedFf;
    nxt_chg    = 1'b0;
    if (cause != causeFf || cause == failedFf) begin
      nxt_cnt = 7'h0;
    end else if (tick) begin
      if (cntFf + 7'h1 >= limit) begin
        nxt_failed = cause;
        nxt_chg    = 1'b1;
        nxt_cnt    = 7'h0;
      end else begin
        nxt_cnt = cntFf + 7'h1;
      end
    end
  end
  // registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      causeFf  <= 1'b0;
      failedFf <= 1'b0;
      chgFf    <= 1'b0;
      cntFf    <= 7'h0;
    end else begin
      causeFf  <= cause;
      failedFf <= nxt_failed;
      chgFf    <= nxt_chg;
      cntFf    <= nxt_cnt;
    end
  end
  assign failed = failedFf;
  assign change = chgFf;
  a_raise_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(failedFf) |-> $past(cntFf) == SET_TICKS - 7'h1 && $past(cause))
    else $error("failure raised before full persistency");
  a_clear_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(failedFf) |-> $past(cntFf) == CLR_TICKS - 7'h1 && !$past(cause))
    else $error("failure cleared before full absence");
  a_timer_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cause != causeFf) |=> cntFf == 7'h0)
    else $error("timer not restarted on cause change");
  c_raise: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(failedFf));
  c_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(failedFf));
endmodule
`default_nettype wire

//--- rtl/fpal_pkg.sv
// constants, types and register map of the fault persistency and alarm log
package fpal_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000; // system clock rate
  localparam int unsigned TICK_MS         = 100;        // filter tick period
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICKS_PER_SEC   = 1000 / TICK_MS;
  localparam int unsigned SET_MS          = 2500;       // raise persistency
  localparam int unsigned CLR_MS          = 10000;      // clear persistency
  localparam logic [6:0]  SET_TICKS       = 7'(SET_MS / TICK_MS);
  localparam logic [6:0]  CLR_TICKS       = 7'(CLR_MS / TICK_MS);
  localparam logic [9:0]  SEC_PER_15M     = 10'h384;    // 900 s
  localparam logic [16:0] SEC_PER_24H     = 17'h15180;  // 86400 s
  localparam int unsigned NUM_CAUSE       = 8;
  localparam int unsigned LOG_DEPTH       = 16;
  localparam logic [4:0]  LOG_FULL        = 5'h10;
  // cause indices
  localparam int unsigned C_LINE_LOSS  = 0;
  localparam int unsigned C_STREAM_LOSS = 6;
  localparam int unsigned C_HW_FAIL    = 7;
  localparam int unsigned NUM_LINE_C   = 6;
  // register indices on the plain port
  localparam logic [3:0] A_CFG    = 4'h0;
  localparam logic [3:0] A_CMD    = 4'h1;
  localparam logic [3:0] A_RTC    = 4'h2;
  localparam logic [3:0] A_PATHID = 4'h3;
  localparam logic [3:0] A_MONPID = 4'h4;
  localparam logic [3:0] A_PPS    = 4'h5;
  localparam logic [3:0] A_FAIL   = 4'h6;
  localparam logic [3:0] A_LOGST  = 4'h7;
  localparam logic [3:0] A_LOGTM  = 4'h8;
  localparam logic [3:0] A_LOGINF = 4'h9;
  localparam logic [3:0] A_DUMP   = 4'hA;
  // command bits
  localparam int unsigned CMD_FLUSH = 0;
  localparam int unsigned CMD_STOP  = 1;
  localparam int unsigned CMD_START = 2;
  // reset values
  localparam logic [5:0]  CFG_RST    = 6'h23;
  localparam logic [11:0] PATHID_RST = 12'h000;
  localparam logic [15:0] DUMP_RST   = 16'h0000;
  typedef struct packed {
    logic wrapMode;     // 1 wrap, 0 stop when full
    logic hecCorrect;   // header error correction active
    logic cellDiscard;  // cell discard active
    logic fmt204;       // 1: 204 bytes with 16 dummy, 0: 188
    logic streamMon;    // stream group monitored
    logic lineMon;      // line group monitored
  } fpal_cfg_type;
  typedef struct packed {
    logic [31:0] stamp; // seconds from local clock
    logic [2:0]  cause; // cause index
    logic        raised; // 1 declared, 0 cleared
  } fpal_rec_type;
endpackage

//--- rtl/fpal_tick.sv
// filter tick and one second tick generator
`timescale 1ns/10ps
`default_nettype none
module fpal_tick import fpal_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic sys_clk, // system clock
  input  wire logic rst_n,   // async reset, low
  output logic      tick,    // filter tick pulse
  output logic      secTick  // one second pulse
);
  logic [31:0] divFf;  // cycle prescaler
  logic [3:0]  subFf;  // ticks within second
  logic        tickFf; // registered tick
  logic        secFf;  // registered second
  logic [31:0] nxt_div;
  logic [3:0]  nxt_sub;
  logic        nxt_tick;
  logic        nxt_sec;
  // prescaler and second subdivider
  always_comb begin
    nxt_div  = divFf + 32'h1;
    nxt_sub  = subFf;
    nxt_tick = 1'b0;
    nxt_sec  = 1'b0;
    if (divFf == TICK_CYCLES - 1) begin
      nxt_div  = 32'h0;
      nxt_tick = 1'b1;
      if (subFf == 4'(TICKS_PER_SEC - 1)) begin
        nxt_sub = 4'h0;
        nxt_sec = 1'b1;
      end else begin
        nxt_sub = subFf + 4'h1;
      end
    end
  end
  // registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divFf  <= 32'h0;
      subFf  <= 4'h0;
      tickFf <= 1'b0;
      secFf  <= 1'b0;
    end else begin
      divFf  <= nxt_div;
      subFf  <= nxt_sub;
      tickFf <= nxt_tick;
      secFf  <= nxt_sec;
    end
  end
  assign tick    = tickFf;
  assign secTick = secFf;
endmodule
`default_nettype wire

//--- rtl/fpal_top.sv
// fault persistency filter, local clock, alarm log and supervision settings
`timescale 1ns/10ps
`default_nettype none
module fpal_top import fpal_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic         sys_clk,     // system clock
  input  wire logic         rst_n,       // async reset, low
  input  wire logic [6:0]   defects,     // defects from basic functions
  input  wire logic         hwFail,      // hardware transfer failure
  input  wire logic [11:0]  monPathId,   // path id seen by monitor
  input  wire logic [15:0]  pktPerSec,   // measured packets per second
  input  wire logic [3:0]   regAddr,     // register index
  input  wire logic [31:0]  regWrData,   // write data
  input  wire logic         regWr,       // write strobe
  input  wire logic         regRd,       // read strobe
  output logic [31:0]       regRdData,   // read data, cycle after strobe
  output fpal_cfg_type      cfgOut,      // supervision and format settings
  output logic [11:0]       pathEntryId, // path id for path entry
  output logic [7:0]        failure,     // declared failures
  output logic              period15,    // 15 minute period start pulse
  output logic              period24,    // 24 hour period start pulse
  output logic              reportValid, // periodic readout record valid
  output fpal_rec_type      reportRec    // periodic readout record
);
  logic tick;     // filter tick
  logic secTick;  // one second tick
  logic [7:0] causeVec;  // gated causes into filters
  logic [7:0] failVec;   // filter outputs
  logic [7:0] failChg;   // filter change pulses

  fpal_tick #(.TICK_CYCLES(TICK_CYCLES)) uTick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (tick),
    .secTick (secTick)
  );

  fpal_cfg_type cfgFf;      // settings register
  logic [11:0]  pathIdFf;   // path entry id
  logic [15:0]  dumpPerFf;  // periodic readout interval, seconds
  logic         recOnFf;    // recording active
  fpal_cfg_type nxt_cfg;
  logic [11:0]  nxt_pathId;
  logic [15:0]  nxt_dumpPer;
  logic         nxt_recOn;
  logic         flush;      // flush command this cycle
  logic         wrHit;      // write strobe helper, address decoded in the case below

  // causes: line group and stream loss gated by supervision
  always_comb begin
    causeVec = 8'h0;
    for (int i = 0; i < NUM_LINE_C; i++) begin
      causeVec[i] = defects[i] & cfgFf.lineMon;
    end
    causeVec[C_STREAM_LOSS] = defects[C_STREAM_LOSS] & cfgFf.streamMon;
    causeVec[C_HW_FAIL]     = hwFail;
  end

  // one independent filter per cause
  for (genvar g = 0; g < NUM_CAUSE; g++) begin : gFilt
    fpal_persist uPers (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .cause   (causeVec[g]),
      .tick    (tick),
      .failed  (failVec[g]),
      .change  (failChg[g])
    );
  end

  // settings and commands written by software
  always_comb begin
    wrHit       = regWr;
    nxt_cfg     = cfgFf;
    nxt_pathId  = pathIdFf;
    nxt_dumpPer = dumpPerFf;
    nxt_recOn   = recOnFf;
    flush       = 1'b0;
    if (wrHit) begin
      case (regAddr)
        A_CFG:    nxt_cfg     = fpal_cfg_type'(regWrData[5:0]);
        A_PATHID: nxt_pathId  = regWrData[11:0];
        A_DUMP:   nxt_dumpPer = regWrData[15:0];
        A_CMD: begin
          flush = regWrData[CMD_FLUSH];
          if (regWrData[CMD_STOP]) begin
            nxt_recOn = 1'b0;
          end else if (regWrData[CMD_START]) begin
            nxt_recOn = 1'b1;
          end
        end
        default: nxt_cfg = cfgFf;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgFf     <= fpal_cfg_type'(CFG_RST);
      pathIdFf  <= PATHID_RST;
      dumpPerFf <= DUMP_RST;
      recOnFf   <= 1'b1;
    end else begin
      cfgFf     <= nxt_cfg;
      pathIdFf  <= nxt_pathId;
      dumpPerFf <= nxt_dumpPer;
      recOnFf   <= nxt_recOn;
    end
  end

  logic [31:0] rtcFf;   // local real-time clock, seconds
  logic [9:0]  sec15Ff; // seconds into 15 minute period
  logic [16:0] sec24Ff; // seconds into 24 hour period
  logic        p15Ff;   // period pulses
  logic        p24Ff;
  logic [31:0] nxt_rtc;
  logic [9:0]  nxt_sec15;
  logic [16:0] nxt_sec24;
  logic        nxt_p15;
  logic        nxt_p24;

  // local clock and period grid, both advanced by the second tick
  always_comb begin
    nxt_rtc   = rtcFf;
    nxt_sec15 = sec15Ff;
    nxt_sec24 = sec24Ff;
    nxt_p15   = 1'b0;
    nxt_p24   = 1'b0;
    if (regWr && regAddr == A_RTC) begin
      nxt_rtc   = regWrData; // clock set realigns the period grid
      nxt_sec15 = 10'h0;
      nxt_sec24 = 17'h0;
    end else if (secTick) begin
      nxt_rtc = rtcFf + 32'h1;
      if (sec15Ff == SEC_PER_15M - 10'h1) begin
        nxt_sec15 = 10'h0;
        nxt_p15   = 1'b1;
      end else begin
        nxt_sec15 = sec15Ff + 10'h1;
      end
      if (sec24Ff == SEC_PER_24H - 17'h1) begin
        nxt_sec24 = 17'h0;
        nxt_p24   = 1'b1;
      end else begin
        nxt_sec24 = sec24Ff + 17'h1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rtcFf   <= 32'h0;
      sec15Ff <= 10'h0;
      sec24Ff <= 17'h0;
      p15Ff   <= 1'b0;
      p24Ff   <= 1'b0;
    end else begin
      rtcFf   <= nxt_rtc;
      sec15Ff <= nxt_sec15;
      sec24Ff <= nxt_sec24;
      p15Ff   <= nxt_p15;
      p24Ff   <= nxt_p24;
    end
  end

  fpal_rec_type memFf [LOG_DEPTH]; // alarm history records
  logic [7:0]  pendFf;   // events waiting for the log
  logic [7:0]  pendDirFf; // direction of each waiting event
  logic [3:0]  headFf;   // oldest record
  logic [4:0]  countFf;  // records held
  logic [7:0]  nxt_pend;
  logic [7:0]  nxt_pendDir;
  logic [3:0]  nxt_head;
  logic [4:0]  nxt_count;
  logic        take;     // one pending event leaves this cycle
  logic [2:0]  sel;      // its index
  logic        push;     // it is stored
  logic        pop;      // software reads the oldest record
  logic        full;
  logic [3:0]  tailPtr;
  fpal_rec_type newRec;

  // pick lowest pending event, store or discard, update pointers
  always_comb begin
    take = 1'b0;
    sel  = 3'h0;
    for (int i = NUM_CAUSE - 1; i >= 0; i--) begin
      if (pendFf[i]) begin
        take = 1'b1;
        sel  = 3'(i);
      end
    end
    full    = (countFf == LOG_FULL);
    tailPtr = headFf + countFf[3:0];
    newRec  = '{stamp: rtcFf, cause: sel, raised: pendDirFf[sel]};
    push    = take && recOnFf && (!full || cfgFf.wrapMode) && !flush;
    pop     = regRd && regAddr == A_LOGINF && countFf != 5'h0 && !flush;
    nxt_pend    = pendFf;
    nxt_pendDir = pendDirFf;
    if (take) begin
      nxt_pend[sel] = 1'b0;
    end
    for (int i = 0; i < NUM_CAUSE; i++) begin
      if (failChg[i]) begin
        nxt_pend[i]    = 1'b1; // new event wins over removal
        nxt_pendDir[i] = failVec[i];
      end
    end
    nxt_head  = headFf;
    nxt_count = countFf;
    if (flush) begin
      nxt_head  = 4'h0;
      nxt_count = 5'h0;
    end else begin
      if (pop) begin
        nxt_head  = nxt_head + 4'h1;
        nxt_count = nxt_count - 5'h1;
      end
      if (push) begin
        if (nxt_count == LOG_FULL) begin
          nxt_head = nxt_head + 4'h1;
        end else begin
          nxt_count = nxt_count + 5'h1;
        end
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pendFf    <= 8'h0;
      pendDirFf <= 8'h0;
      headFf    <= 4'h0;
      countFf   <= 5'h0;
    end else begin
      pendFf    <= nxt_pend;
      pendDirFf <= nxt_pendDir;
      headFf    <= nxt_head;
      countFf   <= nxt_count;
    end
  end
  // record storage, written at the tail
  always_ff @(posedge sys_clk) begin
    if (push) begin
      memFf[tailPtr] <= newRec;
    end
  end

  logic [15:0]  dumpCntFf;  // seconds since last readout
  logic [4:0]   walkLeftFf; // records left to report
  logic [3:0]   walkPtrFf;  // record being reported
  logic         repVFf;
  fpal_rec_type repRecFf;
  logic [15:0]  nxt_dumpCnt;
  logic [4:0]   nxt_walkLeft;
  logic [3:0]   nxt_walkPtr;
  logic         nxt_repV;
  fpal_rec_type nxt_repRec;

  // periodic readout walks the log without removing records
  always_comb begin
    nxt_dumpCnt  = dumpCntFf;
    nxt_walkLeft = walkLeftFf;
    nxt_walkPtr  = walkPtrFf;
    nxt_repV     = 1'b0;
    nxt_repRec   = repRecFf;
    if (walkLeftFf != 5'h0 && !flush) begin
      nxt_repV     = 1'b1;
      nxt_repRec   = memFf[walkPtrFf];
      nxt_walkPtr  = walkPtrFf + 4'h1;
      nxt_walkLeft = walkLeftFf - 5'h1;
    end else if (flush) begin
      nxt_walkLeft = 5'h0;
    end
    if (dumpPerFf == 16'h0) begin
      nxt_dumpCnt = 16'h0;
    end else if (secTick) begin
      if (dumpCntFf + 16'h1 >= dumpPerFf) begin
        nxt_dumpCnt = 16'h0;
        if (walkLeftFf == 5'h0 && !flush) begin
          nxt_walkLeft = countFf;
          nxt_walkPtr  = headFf;
        end
      end else begin
        nxt_dumpCnt = dumpCntFf + 16'h1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dumpCntFf  <= 16'h0;
      walkLeftFf <= 5'h0;
      walkPtrFf  <= 4'h0;
      repVFf     <= 1'b0;
      repRecFf   <= '0;
    end else begin
      dumpCntFf  <= nxt_dumpCnt;
      walkLeftFf <= nxt_walkLeft;
      walkPtrFf  <= nxt_walkPtr;
      repVFf     <= nxt_repV;
      repRecFf   <= nxt_repRec;
    end
  end

  logic [31:0] rdFf;  // read data register
  logic [31:0] nxt_rd;
  fpal_rec_type headRec;
  // read mux, data stands the cycle after the strobe
  always_comb begin
    headRec = memFf[headFf];
    nxt_rd  = 32'h0;
    if (regRd) begin
      case (regAddr)
        A_CFG:    nxt_rd = {26'h0, cfgFf};
        A_RTC:    nxt_rd = rtcFf;
        A_PATHID: nxt_rd = {20'h0, pathIdFf};
        A_MONPID: nxt_rd = {20'h0, monPathId};
        A_PPS:    nxt_rd = {16'h0, pktPerSec};
        A_FAIL:   nxt_rd = {24'h0, failVec};
        A_LOGST:  nxt_rd = {24'h0, recOnFf, cfgFf.wrapMode, full, countFf};
        A_LOGTM:  nxt_rd = (countFf != 5'h0) ? headRec.stamp : 32'h0;
        A_LOGINF: nxt_rd = (countFf != 5'h0) ?
                           {23'h0, 1'b1, 4'h0, headRec.raised, headRec.cause}
                           : 32'h0;
        A_DUMP:   nxt_rd = {16'h0, dumpPerFf};
        default:  nxt_rd = 32'h0;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdFf <= 32'h0;
    end else begin
      rdFf <= nxt_rd;
    end
  end

  assign regRdData   = rdFf;
  assign cfgOut      = cfgFf;
  assign pathEntryId = pathIdFf;
  assign failure     = failVec;
  assign period15    = p15Ff;
  assign period24    = p24Ff;
  assign reportValid = repVFf;
  assign reportRec   = repRecFf;

  a_flush_empties: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flush |=> countFf == 5'h0 && walkLeftFf == 5'h0)
    else $error("flush left records behind");
  a_wrap_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && full && !pop |=> countFf == LOG_FULL && headFf == $past(headFf) + 4'h1)
    else $error("wrap did not drop oldest record");
  a_stop_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && full && !cfgFf.wrapMode && !pop && !flush |=>
      countFf == LOG_FULL && headFf == $past(headFf))
    else $error("stop mode changed a full log");
  a_stop_record: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !recOnFf && !pop && !flush |=> countFf == $past(countFf))
    else $error("log grew while recording stopped");
  a_rtc_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    secTick && !(regWr && regAddr == A_RTC) |=> rtcFf == $past(rtcFf) + 32'h1)
    else $error("local clock missed a second");
  a_pps_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regRd && regAddr == A_PPS |=> regRdData == {16'h0, $past(pktPerSec)})
    else $error("packet rate read wrong");
  a_loss_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cfgFf.lineMon [*8] |-> !failChg[C_LINE_LOSS] || !failVec[C_LINE_LOSS])
    else $error("line loss raised while unmonitored");
  a_event_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |failChg |=> |pendFf)
    else $error("failure change lost before logging");
  c_wrap: cover property (@(posedge sys_clk) disable iff (!rst_n)
    push && full);
  c_dump: cover property (@(posedge sys_clk) disable iff (!rst_n)
    repVFf);
  c_pop: cover property (@(posedge sys_clk) disable iff (!rst_n)
    pop ##1 regRdData[8]);
endmodule
`default_nettype wire

//--- sim/fpal_fault_src.sv
// model of the basic functions that feed fault causes to the filter
`timescale 1ns/10ps
`default_nettype none
module fpal_fault_src #(
  parameter logic [11:0] PATH_ID  = 12'h5A3, // path id seen on the cells
  parameter logic [15:0] PKT_RATE = 16'h1F40 // measured packet rate
) (
  input  wire logic [7:0]  faultReq,  // commanded faults, bit 7 hardware
  output logic      [6:0]  defects,   // transmission defects, active high
  output logic             hwFail,    // hardware transfer failure
  output logic      [11:0] monPathId, // path id seen by the monitor
  output logic      [15:0] pktPerSec  // measured packet rate
);
  // levels follow the command, which changes only after a clock edge
  assign defects   = faultReq[6:0];
  assign hwFail    = faultReq[7];
  assign monPathId = PATH_ID;
  assign pktPerSec = PKT_RATE;
endmodule
`default_nettype wire

//--- sim/fpal_top_bench.sv
// self-checking bench of the fault filter and alarm log
`timescale 1ns/10ps
`default_nettype none
module fpal_top_bench;
  import fpal_pkg::*;
  logic         sys_clk = 1'b0;     // system clock
  logic         rst_n = 1'b0;       // async reset, low
  logic [7:0]   faultReq = 8'h00;   // faults commanded to the model
  logic [6:0]   defects;            // defects into the block
  logic         hwFail;             // hardware failure into the block
  logic [11:0]  monPathId;          // path id from the model
  logic [15:0]  pktPerSec;          // packet rate from the model
  logic [3:0]   regAddr = 4'h0;     // register index
  logic [31:0]  regWrData = 32'h0;  // write data
  logic         regWr = 1'b0;       // write strobe
  logic         regRd = 1'b0;       // read strobe
  logic [31:0]  regRdData;          // read data
  fpal_cfg_type cfgOut;             // settings out
  logic [11:0]  pathEntryId;        // path id out
  logic [7:0]   failure;            // declared failures
  logic         reportValid;        // periodic record strobe
  logic         period15;           // 15 minute period start pulse
  logic         period24;           // 24 hour period start pulse
  int           p15Count = 0;       // 15 minute pulses seen
  int           p24Count = 0;       // 24 hour pulses seen
  fpal_rec_type reportRec;          // periodic record
  logic [31:0]  rdv;                // last read value
  int           num_errors = 0;     // mismatches
  int           checks = 0;         // comparisons
  int           reports = 0;        // periodic records seen
  // clock, 25 ns period
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  fpal_fault_src i_fpal_fault_src (.faultReq(faultReq), .defects(defects),
    .hwFail(hwFail), .monPathId(monPathId), .pktPerSec(pktPerSec));
  fpal_top #(.TICK_CYCLES(4)) i_fpal_top (.sys_clk(sys_clk), .rst_n(rst_n),
    .defects(defects), .hwFail(hwFail), .monPathId(monPathId),
    .pktPerSec(pktPerSec), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cfgOut(cfgOut),
    .pathEntryId(pathEntryId), .failure(failure), .period15(period15),
    .period24(period24), .reportValid(reportValid), .reportRec(reportRec));
  // count periodic readout records and period start pulses
  always @(posedge sys_clk) begin
    if (reportValid === 1'b1) begin
      reports++;
    end
    if (period15 === 1'b1) begin
      p15Count++;
    end
    if (period24 === 1'b1) begin
      p24Count++;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one write cycle, then one idle edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // one read cycle; data sampled in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    rdv = regRdData;
    @(posedge sys_clk);
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    cyc(60000);
    num_errors++;
    summarize();
  end
  initial begin
    cyc(8);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(A_CFG); chk(rdv, {26'h0, CFG_RST});
    rd(A_LOGST); chk(rdv, 32'hC0);
    wr(A_CFG, 32'h3F); rd(A_CFG); chk(rdv, 32'h3F);
    chk({26'h0, cfgOut}, 32'h3F);
    wr(A_PATHID, 32'hABC); rd(A_PATHID); chk(rdv, 32'hABC);
    chk({20'h0, pathEntryId}, 32'hABC);
    rd(A_MONPID); chk(rdv, 32'h5A3);
    rd(A_PPS); chk(rdv, 32'h1F40);
    wr(4'hB, 32'hFF); rd(4'hB); chk(rdv, 32'h0);
    wr(A_CFG, 32'h22);
    // line group unmonitored: loss masked, hardware fault still counts
    faultReq <= 8'h81;
    cyc(110); chk(failure, 8'h80);
    faultReq <= 8'h00; wr(A_CFG, 32'h23); cyc(410);
    chk(failure, 8'h00);
    // a short gap restarts the raise timer
    faultReq <= 8'h04; cyc(60); faultReq <= 8'h00; cyc(10);
    faultReq <= 8'h04; cyc(60); chk(failure, 8'h00);
    cyc(45); chk(failure, 8'h04);
    rd(A_FAIL); chk(rdv, 32'h04);
    faultReq <= 8'h00; cyc(390); chk(failure, 8'h04);
    cyc(20); chk(failure, 8'h00);
    wr(A_CMD, 32'h1); rd(A_LOGST); chk(rdv, 32'hC0);
    // seventeen events into a sixteen deep log in wrap mode
    for (int i = 0; i < 9; i++) begin
      faultReq <= 8'h80; cyc(110);
      if (i < 8) begin
        faultReq <= 8'h00; cyc(410);
      end
    end
    rd(A_LOGST); chk(rdv, 32'hF0);
    rd(A_LOGINF); chk(rdv, 32'h107);
    wr(A_CMD, 32'h2); rd(A_LOGST); chk(rdv, 32'h4F);
    wr(A_CMD, 32'h1); rd(A_LOGST); chk(rdv, 32'h40);
    wr(A_CMD, 32'h4); rd(A_LOGST); chk(rdv, 32'hC0);
    // one cleared record, then periodic readout each second
    faultReq <= 8'h00; cyc(420);
    rd(A_LOGST); chk(rdv, 32'hC1);
    wr(A_DUMP, 32'h1); cyc(90);
    chk({31'h0, reports != 0}, 32'h1);
    chk({28'h0, reportRec.cause, reportRec.raised}, 32'hE);
    rd(A_LOGINF); chk(rdv, 32'h107);
    rd(A_LOGTM); chk(rdv, 32'h0);
    // clock set restarts the grid: first 15 minute start 900 s later
    wr(A_RTC, 32'h100); cyc(35950); chk(p15Count, 0);
    @(posedge sys_clk iff period15 === 1'b1);
    rd(A_RTC); chk(rdv, 32'h484);
    cyc(5); chk(p15Count, 1);
    chk(p24Count, 0);
    summarize();
  end
endmodule
`default_nettype wire
